// ===== dv/bra_arbiter_monitor.sv
// Checker for the bus ownership controller
`timescale 1ns/1ps
`default_nettype none
module bra_arbiter_monitor (
  input wire logic sys_clk,             // Clock
  input wire logic rst_n,               // Reset
  input wire logic rd_ready,            // Read taken
  input wire logic wr_valid,            // Write req
  input wire logic wr_ready,            // Queue room
  input wire logic dc_enable,           // Cache on
  input wire logic dc_hit,              // Cache hit
  input wire logic dc_update,           // Line update
  input wire logic sync_instruction,    // Sync
  input wire logic exec_stall,          // Stall
  input wire logic bus_request_n,       // Request
  input wire logic bus_busy_in_n,       // Busy wire
  input wire logic bus_busy_oe_n,       // Busy enable
  input wire logic bus_drive_oe_n,      // Bus enable
  input wire logic transfer_start_n,    // Start
  input wire logic atomic_last_write_n, // Lock end
  input wire logic bus_write,           // Direction
  input wire logic transfer_ack_n       // Ack
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Pins are synchronised, so a cycle always runs some clocks
  sequence s_start; !transfer_start_n; endsequence
  sequence s_no_ack; transfer_ack_n[*2]; endsequence
  property p_req; s_start |-> !$past(bus_request_n); endproperty
  property p_rd; rd_ready |=> s_start and !bus_write; endproperty
  property p_own; s_start |-> !bus_busy_oe_n && !bus_drive_oe_n; endproperty
  property p_gap; s_start |=> transfer_start_n[*3]; endproperty
  property p_hold; s_start ##1 s_no_ack |-> !bus_busy_oe_n; endproperty
  property p_lock; !atomic_last_write_n |-> bus_write && !bus_busy_oe_n;
  endproperty
  property p_dc; dc_update == (wr_valid && wr_ready && dc_enable && dc_hit);
  endproperty
  property p_stall; sync_instruction && !bus_request_n |-> exec_stall;
  endproperty
  property p_take; $fell(bus_busy_oe_n) |-> $past(bus_busy_in_n); endproperty
  a_req: assert property (p_req)
    else $error("start without request");
  a_rd: assert property (p_rd)
    else $error("read taken without start");
  a_own: assert property (p_own)
    else $error("start without ownership");
  a_gap: assert property (p_gap)
    else $error("start inside a cycle");
  a_hold: assert property (p_hold)
    else $error("busy dropped mid cycle");
  a_lock: assert property (p_lock)
    else $error("lock end outside write");
  a_dc: assert property (p_dc)
    else $error("cache update mismatch");
  a_stall: assert property (p_stall)
    else $error("no stall while pending");
  a_take: assert property (p_take)
    else $error("busy taken while held");
endmodule // bra_arbiter_monitor
bind bra_arbiter bra_arbiter_monitor bra_arbiter_monitor_i (.sys_clk, .rst_n,
  .rd_ready, .wr_valid, .wr_ready, .dc_enable, .dc_hit, .dc_update,
  .sync_instruction, .exec_stall, .bus_request_n, .bus_busy_in_n,
  .bus_busy_oe_n, .bus_drive_oe_n, .transfer_start_n, .atomic_last_write_n,
  .bus_write, .transfer_ack_n);
`default_nettype wire

// ===== dv/bra_arbiter_tb.sv
// Self-checking bench for the bus ownership controller
`timescale 1ns/1ps
`default_nettype none
module bra_arbiter_tb;
  logic sys_clk, rst_n, rd_valid, rd_ready, rd_done, wr_valid, wr_ready;
  logic dc_enable, dc_hit, dc_update, sync_instruction, exec_stall, deny;
  logic bus_request_n, bus_grant_n, bus_busy_in_n, bus_busy_out_n;
  logic bus_busy_oe_n, bus_drive_oe_n, transfer_start_n, atomic_last_write_n;
  logic              bus_write, transfer_ack_n;
  logic [31:0]       rd_data, bus_addr, bus_wdata, bus_rdata;
  logic [1:0]        dly;
  logic [2:0]        beats;
  bra_pkg::bra_req_s rd_req, wr_req;
  logic [32:0]       log_q[$];
  int                miscompares, checks_done, cyc;
  bra_arbiter bra_arbiter_i (.sys_clk, .rst_n, .rd_valid, .rd_req, .rd_ready,
    .rd_data, .rd_done, .wr_valid, .wr_req, .wr_ready, .dc_enable, .dc_hit,
    .dc_update, .sync_instruction, .exec_stall, .bus_request_n, .bus_grant_n,
    .bus_busy_in_n, .bus_busy_out_n, .bus_busy_oe_n, .bus_drive_oe_n,
    .transfer_start_n, .atomic_last_write_n, .bus_addr, .bus_wdata,
    .bus_write, .bus_rdata, .transfer_ack_n, .transfer_error_ack_n(1'b1));
  bra_far_model bra_far_model_i (.sys_clk, .rst_n, .deny, .dly, .beats,
    .bus_request_n, .bus_busy_oe_n, .bus_busy_out_n, .transfer_start_n,
    .bus_addr, .bus_grant_n, .bus_busy_in_n, .transfer_ack_n, .bus_rdata);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Log every start; cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (transfer_start_n === 1'b0) log_q.push_back({bus_write, bus_addr});
    if (cyc == 3000) begin
      miscompares++;
      stop_test;
    end
  end
  task automatic stop_test;
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [32:0] exp, logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // Drives change at the falling edge, looked at 1 ns later
  task automatic wr(logic [31:0] a, logic hit, logic le);
    @(negedge sys_clk);
    wr_req = '{a, ~a, 1'b0, le, le, 1'b0};
    dc_hit = hit;
    wr_valid = 1'b1;
    #1;
    while (wr_ready !== 1'b1) begin
      @(negedge sys_clk);
      #1;
    end
    cmp("dc_update", {32'h0, hit & dc_enable}, {32'h0, dc_update});
    @(negedge sys_clk);
    wr_valid = 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic ser, logic ln);
    @(negedge sys_clk);
    rd_req = '{a, 32'h0, ln, 1'b0, 1'b0, ser};
    rd_valid = 1'b1;
    deny = 1'b0;
    #1;
    while (rd_ready !== 1'b1) begin
      @(negedge sys_clk);
      #1;
    end
    @(negedge sys_clk);
    rd_valid = 1'b0;
    while (rd_done !== 1'b1) @(negedge sys_clk);
    cmp("rd_data", {1'b0, a ^ 32'hA5A5A5A5}, {1'b0, rd_data});
  endtask
  // Sync until the bus is quiet; doubles as the stall check
  task automatic drain;
    @(negedge sys_clk);
    sync_instruction = 1'b1;
    #1;
    while (exec_stall !== 1'b0) begin
      @(negedge sys_clk);
      #1;
    end
    cmp("request_idle", 33'h1, {32'h0, bus_request_n});
    sync_instruction = 1'b0;
  endtask
  task automatic t_order;
    log_q = {};
    deny = 1'b1;
    wr(32'h0000_0100, 1'b1, 1'b0);
    wr(32'h0000_0200, 1'b0, 1'b1);
    rd(32'h0000_0300, 1'b0, 1'b0);
    drain;
    cmp("first", {1'b0, 32'h0000_0300}, log_q[0]);
    cmp("second", {1'b1, 32'h0000_0100}, log_q[1]);
    cmp("third", {1'b1, 32'h0000_0200}, log_q[2]);
  endtask
  // Read that must wait for a queued write
  task automatic t_pass(logic [31:0] wa, logic [31:0] ra, logic ser);
    log_q = {};
    deny = 1'b1;
    wr(wa, 1'b1, 1'b0);
    rd(ra, ser, 1'b0);
    drain;
    cmp("write_first", {1'b1, wa}, log_q[0]);
    cmp("read_after", {1'b0, ra}, log_q[1]);
  endtask
  task automatic t_stall;
    deny = 1'b1;
    wr(32'h0000_0800, 1'b1, 1'b0);
    @(negedge sys_clk);
    sync_instruction = 1'b1;
    #1;
    cmp("stall", 33'h1, {32'h0, exec_stall});
    deny = 1'b0;
    drain;
  endtask
  // Grant withdrawn in a four-beat line: finish, then let go
  task automatic t_line;
    log_q = {};
    beats = 3'h4;
    dly = 2'h1;
    fork
      rd(32'h0000_0700, 1'b0, 1'b1);
      begin
        @(negedge sys_clk iff transfer_start_n === 1'b0);
        deny = 1'b1;
      end
    join
    while (bus_busy_oe_n !== 1'b1) @(negedge sys_clk);
    cmp("line_starts", 33'h1, 33'(log_q.size()));
    cmp("bus_off", 33'h1, {32'h0, bus_drive_oe_n});
  endtask
  initial begin
    rst_n = 1'b0;
    rd_valid = 1'b0;
    wr_valid = 1'b0;
    rd_req = '0;
    wr_req = '0;
    dc_enable = 1'b1;
    dc_hit = 1'b0;
    sync_instruction = 1'b0;
    deny = 1'b0;
    dly = 2'h0;
    beats = 3'h1;
    cyc = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    rd(32'h0000_0010, 1'b0, 1'b0);
    drain;
    t_order;
    dc_enable = 1'b0;
    t_pass(32'h0000_0400, 32'h0000_0400, 1'b0);
    t_pass(32'h0000_0500, 32'h0000_0600, 1'b1);
    t_stall;
    t_line;
    stop_test;
  end
endmodule // bra_arbiter_tb
`default_nettype wire

// ===== dv/bra_far_model.sv
// Far side: arbiter, busy pull-up and a slave memory
`timescale 1ns/1ps
`default_nettype none
module bra_far_model (
  input  wire logic        sys_clk,          // Clock
  input  wire logic        rst_n,            // Reset
  input  wire logic        deny,             // Withhold grant
  input  wire logic [1:0]  dly,              // Wait states
  input  wire logic [2:0]  beats,            // Acks per cycle
  input  wire logic        bus_request_n,    // Request
  input  wire logic        bus_busy_oe_n,    // Busy enable
  input  wire logic        bus_busy_out_n,   // Busy value
  input  wire logic        transfer_start_n, // Start
  input  wire logic [31:0] bus_addr,         // Address
  output logic             bus_grant_n,      // Grant
  output logic             bus_busy_in_n,    // Busy wire
  output logic             transfer_ack_n,   // Ack
  output logic [31:0]      bus_rdata         // Read data
);
  logic [2:0] left_ff;
  logic [1:0] wait_ff;
  // Busy floats high when undriven; data is junk off the ack edge
  assign bus_busy_in_n = bus_busy_oe_n ? 1'b1 : bus_busy_out_n;
  assign bus_rdata = transfer_ack_n ? ~bus_addr : bus_addr ^ 32'hA5A5A5A5;
  // Grant follows request, so a gap edge separates tenures
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_grant_n    <= 1'b1;
      transfer_ack_n <= 1'b1;
      left_ff        <= 3'h0;
      wait_ff        <= 2'h0;
    end else begin
      // Grant drops when request is released or when the bench sets deny, lock or not
      bus_grant_n    <= bus_request_n | deny;
      transfer_ack_n <= !(left_ff != 3'h0 && wait_ff == 2'h0);
      if (!transfer_start_n) begin
        left_ff <= beats;
        wait_ff <= dly;
      end else if (left_ff != 3'h0 && wait_ff == 2'h0) begin
        left_ff <= left_ff - 3'h1;
        wait_ff <= dly;
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule // bra_far_model
`default_nettype wire

// ===== rtl/bra_arbiter.sv
// Bus ownership and pending access ordering controller
//
// Overview of operation
// [RULE_01] Operand reads beat waiting writes
// [RULE_02] Read address hitting pending write waits
// [RULE_03] Reads in order, writes in order
// [RULE_04] Serialized read waits for writes drained
// [RULE_05] Serialized pages alter reads only
// [RULE_06] Sync instruction stalls until bus idle
// [RULE_07] Cache write hit updates line early
// [RULE_08] One idle clock between bus owners
// [RULE_09] State changes only on rising edge
// [RULE_10] Request asserted while any access pending
// [RULE_11] Granted: request asserted with transfer start; here the start strobe comes one clock after request
// [RULE_12] Request always actively driven
// [RULE_13] Grant lost mid-cycle: finish, then release
// [RULE_14] Arbiter negates grant before final ack
// [RULE_15] Four-beat line is one cycle
// [RULE_16] Locked read and write are divisible
// [RULE_17] Arbiter may hold grant during lock
// [RULE_18] Last locked write flagged separately
// [RULE_19] Granted: wait busy free, then start
// [RULE_20] Busy held while granted, then released
// [RULE_21] Granted: keep busy and drive bus
// [RULE_22] Request dropped when nothing pending
// [RULE_23] Granted, idle: implicit ownership, busy floats
// [RULE_24] Arbiter leaves one clock with no grants
// [RULE_25] Controls active low, sampled rising edge
`timescale 1ns/1ps
`default_nettype none

module bra_arbiter (
  input  wire logic              sys_clk,             // Bus clock
  input  wire logic              rst_n,               // Sync reset
  // Read port from the operand fetch stage
  input  wire logic              rd_valid,            // Read request
  input  wire bra_pkg::bra_req_s rd_req,              // Read attributes
  output logic                   rd_ready,            // Read accepted
  output logic [31:0]            rd_data,             // Read return data
  output logic                   rd_done,             // Read data pulse
  // Write port from the write-back stage
  input  wire logic              wr_valid,            // Write request
  input  wire bra_pkg::bra_req_s wr_req,              // Write attributes
  output logic                   wr_ready,            // Write queued
  // Data cache write-hit update
  input  wire logic              dc_enable,           // Data cache on
  input  wire logic              dc_hit,              // Write hits cache
  output logic                   dc_update,           // Update line now
  // Synchronizing instruction
  input  wire logic              sync_instruction,    // Sync executing
  output logic                   exec_stall,          // Freeze execution
  // External arbitration and transfer pins
  output logic                   bus_request_n,       // Always driven
  input  wire logic              bus_grant_n,         // Grant pin
  input  wire logic              bus_busy_in_n,       // Busy pin level
  output logic                   bus_busy_out_n,      // Busy drive value
  output logic                   bus_busy_oe_n,       // Busy enable, low
  output logic                   bus_drive_oe_n,      // Bus enable, low
  output logic                   transfer_start_n,    // Start strobe
  output logic                   atomic_last_write_n, // Final lock write
  output logic [31:0]            bus_addr,            // Address out
  output logic [31:0]            bus_wdata,           // Write data out
  output logic                   bus_write,           // Direction
  input  wire logic [31:0]       bus_rdata,           // Read data in
  input  wire logic              transfer_ack_n,      // Transfer ack pin
  input  wire logic              transfer_error_ack_n // Error ack pin
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic [31:0] rdata_meta_ff;
  logic [31:0] rdata_ff;

  // Two stages before any logic looks at a pin
  always_ff @(posedge sys_clk) begin                         // see [RULE_25]
    meta_ff  <= {bus_grant_n, bus_busy_in_n, transfer_ack_n,
                 transfer_error_ack_n};
    sync_ff  <= meta_ff;
    // Data takes the same two stages so it lines up with the ack
    rdata_meta_ff <= bus_rdata;
    rdata_ff      <= rdata_meta_ff;
  end

  wire granted   = ~sync_ff[3];
  wire busy_ext  = ~sync_ff[2];
  wire ack_any   = ~sync_ff[1] | ~sync_ff[0];  // Normal or error ends beat

  // ------------------------------------------------------------------
  // Pending write queue
  // ------------------------------------------------------------------
  bra_pkg::bra_req_s wq_mem [bra_pkg::WQ_DEPTH];
  logic [bra_pkg::WQ_PTR_W-1:0] wq_rd_ff;
  logic [bra_pkg::WQ_PTR_W-1:0] wq_wr_ff;
  logic [bra_pkg::WQ_PTR_W:0]   wq_cnt_ff;

  wire wq_empty = (wq_cnt_ff == '0);
  wire wq_full  = (wq_cnt_ff == bra_pkg::WQ_FULL_CNT);
  wire wq_push  = wr_valid & ~wq_full;
  logic wq_pop;

  // Address collision against every queued write
  logic collide;
  always_comb begin
    collide = 1'b0;
    for (int i = 0; i < bra_pkg::WQ_DEPTH; i++) begin
      if ((i < int'(wq_cnt_ff)) &&
          (wq_mem[(int'(wq_rd_ff) + i) % bra_pkg::WQ_DEPTH].addr ==
           rd_req.addr))
        collide = 1'b1;                                       // see [RULE_02]
    end
  end

  // Queue storage; writes leave strictly in arrival order
  always_ff @(posedge sys_clk) begin                          // see [RULE_03]
    if (!rst_n) begin
      wq_rd_ff  <= '0;
      wq_wr_ff  <= '0;
      wq_cnt_ff <= '0;
    end else begin
      if (wq_push) begin
        wq_mem[wq_wr_ff] <= wr_req;
        wq_wr_ff         <= wq_wr_ff + 1'b1;
      end
      if (wq_pop)
        wq_rd_ff <= wq_rd_ff + 1'b1;
      wq_cnt_ff <= wq_cnt_ff + {2'h0, wq_push} - {2'h0, wq_pop};
    end
  end

  assign wr_ready  = ~wq_full;
  // Cache line updated at once; later code may see it early
  assign dc_update = wq_push & dc_enable & dc_hit;            // see [RULE_07]

  // ------------------------------------------------------------------
  // Next cycle selection
  // ------------------------------------------------------------------
  // Serial attribute ignored on writes: they queue identically
  wire rd_blocked = collide | (rd_req.serial & ~wq_empty);    // see [RULE_04]
  wire rd_pick    = rd_valid & ~rd_blocked;                   // see [RULE_01]
  wire wr_pick    = ~rd_pick & ~wq_empty;                     // see [RULE_05]
  wire any_pend   = rd_valid | ~wq_empty;

  bra_pkg::bra_cyc_s nxt_cyc;
  always_comb begin
    nxt_cyc.addr     = rd_pick ? rd_req.addr : wq_mem[wq_rd_ff].addr;
    nxt_cyc.data     = wq_mem[wq_rd_ff].data;
    nxt_cyc.write    = ~rd_pick;
    nxt_cyc.line     = rd_pick ? rd_req.line : wq_mem[wq_rd_ff].line;
    nxt_cyc.lock_end = ~rd_pick & wq_mem[wq_rd_ff].lock_end;
  end

  // ------------------------------------------------------------------
  // Arbitration state machine
  // ------------------------------------------------------------------
  bra_pkg::bra_state_e state_ff;
  bra_pkg::bra_state_e nxt_state;
  bra_pkg::bra_cyc_s   cyc_ff;
  logic [1:0]          beat_ff;
  logic                ts_ff;

  wire can_start = (rd_pick | wr_pick);
  wire last_beat = ack_any & (~cyc_ff.line |
                   (beat_ff == bra_pkg::LINE_BEATS_LAST));    // see [RULE_15]
  wire start_now = can_start & granted &
                   ((state_ff == bra_pkg::ST_WAITBB & ~busy_ext) |
                    state_ff == bra_pkg::ST_PARK |
                    state_ff == bra_pkg::ST_IMPL |
                    (state_ff == bra_pkg::ST_ACTIVE & last_beat));
                                                              // see [RULE_19]

  // Transitions; locked halves are separate cycles, so the bus may
  // be lost between them
  always_comb begin                                           // see [RULE_16]
    nxt_state = state_ff;
    case (state_ff)
      bra_pkg::ST_IDLE:
        if (granted)
          nxt_state = bra_pkg::ST_WAITBB;
      bra_pkg::ST_WAITBB:
        if (!granted)
          nxt_state = bra_pkg::ST_IDLE;
        else if (!busy_ext)
          nxt_state = start_now ? bra_pkg::ST_ACTIVE
                                : bra_pkg::ST_IMPL;           // see [RULE_23]
      bra_pkg::ST_ACTIVE:
        if (last_beat) begin
          if (!granted)
            nxt_state = bra_pkg::ST_IDLE;                     // see [RULE_13]
          else if (!start_now)
            nxt_state = bra_pkg::ST_PARK;                     // see [RULE_21]
        end
      bra_pkg::ST_PARK, bra_pkg::ST_IMPL:
        if (!granted)
          nxt_state = bra_pkg::ST_IDLE;
        else if (start_now)
          nxt_state = bra_pkg::ST_ACTIVE;
      default:
        nxt_state = bra_pkg::ST_IDLE;
    endcase
  end

  // Registered state, cycle and beat count on the rising edge only
  always_ff @(posedge sys_clk) begin                          // see [RULE_09]
    if (!rst_n) begin
      state_ff <= bra_pkg::ST_IDLE;
      beat_ff  <= '0;
      ts_ff    <= 1'b0;
      cyc_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      ts_ff    <= start_now;
      if (start_now) begin
        cyc_ff  <= nxt_cyc;
        beat_ff <= '0;
      end else if (state_ff == bra_pkg::ST_ACTIVE && ack_any) begin
        beat_ff <= beat_ff + 1'b1;
      end
    end
  end

  assign wq_pop   = start_now & wr_pick;
  assign rd_ready = start_now & rd_pick;

  // Read data returns on the final beat of a read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_done <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_done <= (state_ff == bra_pkg::ST_ACTIVE) & last_beat &
                 ~cyc_ff.write;
      if ((state_ff == bra_pkg::ST_ACTIVE) && last_beat)
        rd_data <= rdata_ff;
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  wire owns = (state_ff == bra_pkg::ST_ACTIVE) |
              (state_ff == bra_pkg::ST_PARK);
  logic owned_ff;

  // Remembers ownership so busy is driven high once before floating
  always_ff @(posedge sys_clk) begin
    if (!rst_n)
      owned_ff <= 1'b0;
    else
      owned_ff <= owns;
  end

  // Request is a push-pull level that follows pending work
  assign bus_request_n  = ~(any_pend | start_now);  // see [RULE_10] [RULE_22]
  // Never open-drain: no other requester may share this pin
  // see [RULE_12]
  // Busy negated for one clock after release, then floats
  assign bus_busy_out_n = ~owns;                              // see [RULE_20]
  assign bus_busy_oe_n  = ~(owns | owned_ff);                 // see [RULE_08]
  assign bus_drive_oe_n = ~(owns | state_ff == bra_pkg::ST_IMPL);
  // Start strobe is start_now registered, one clock after request when already granted
  assign transfer_start_n    = ~ts_ff;                        // see [RULE_11]
  assign atomic_last_write_n = ~((state_ff == bra_pkg::ST_ACTIVE) &
                                 cyc_ff.lock_end);            // see [RULE_18]
  assign bus_addr  = cyc_ff.addr;
  assign bus_wdata = cyc_ff.data;
  assign bus_write = cyc_ff.write;
  // Sync freezes execution while any cycle is still outstanding
  assign exec_stall = sync_instruction &
                      (any_pend | state_ff == bra_pkg::ST_ACTIVE);
                                                              // see [RULE_06]

endmodule : bra_arbiter

`default_nettype wire

// ===== rtl/bra_pkg.sv
// Package: types and constants for bus request and access ordering
package bra_pkg;

  // Pending write queue depth and width
  localparam int unsigned WQ_DEPTH = 4;
  localparam int unsigned WQ_PTR_W = 2;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned DATA_W   = 32;
  // Index of the last of four transfers in one burst-inhibited line access
  localparam logic [1:0]  LINE_BEATS_LAST = 2'h3;
  localparam logic [WQ_PTR_W:0] WQ_FULL_CNT = 3'h4;

  // Internal access request from the memory units
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              line;     // Four-beat burst-inhibited line
    logic              locked;   // Part of a locked sequence
    logic              lock_end; // Final write of a locked sequence
    logic              serial;   // Serialized noncachable page
  } bra_req_s;

  // Bus cycle handed to the transfer logic
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              write;
    logic              line;
    logic              lock_end;
  } bra_cyc_s;

  // Arbitration states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01, // Not owner, bus not driven
    ST_WAITBB = 5'h02, // Granted, waiting for busy release
    ST_ACTIVE = 5'h04, // Running a bus cycle
    ST_PARK   = 5'h08, // Owner, busy held, no cycle
    ST_IMPL   = 5'h10  // Granted, no cycle, busy not driven
  } bra_state_e;

endpackage : bra_pkg
